// ==== verilog/unb_stage_pkg.sv ====
// Constants and types shared by the unbalance stage blocking, event and record logic
//=============================================================================
package unb_stage_pkg;
  localparam int CLK_PERIOD_NS  = 10;
  localparam int PROG_CYCLE_MS  = 5;
  localparam int PROG_CYCLE_CLK = PROG_CYCLE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int DELAY_STEP_MS  = 5;
  localparam int PRE_TRIG_MS    = 20;
  localparam int PREFAULT_MS    = 200;
  localparam int PRE_TRIG_CYC   = PRE_TRIG_MS / PROG_CYCLE_MS;
  localparam int HIST_DEPTH     = PREFAULT_MS / PROG_CYCLE_MS;
  localparam int REC_DEPTH      = 12;
  localparam int NUM_STATUS     = 6;
  localparam int NUM_COUNTERS   = 5;
  localparam int CUR_W          = 16;
  localparam int CNT_W          = 16;
  // Unbalance in 0.01 units: diff / (sum/3) * 100
  localparam logic [9:0]  UNB_SCALE    = 10'h012C;
  localparam logic [6:0]  PCT_FULL     = 7'h64;
  localparam logic [6:0]  RELEASE_PCT  = 7'h61;
  localparam logic [15:0] HARM_LIM_DEF = 16'h07D0;
  localparam logic [15:0] DELAY_DEF    = 16'h0008;
  localparam logic        HARM_EN_DEF  = 1'b0;
  // Status bit positions; also the event pair index
  localparam int ST_ALM_START = 0;
  localparam int ST_ALARM     = 1;
  localparam int ST_START     = 2;
  localparam int ST_TRIP      = 3;
  localparam int ST_BLOCK     = 4;
  localparam int ST_HARM      = 5;

  typedef enum logic [3:0] {
    EV_ALM_START_ON  = 4'h0,
    EV_ALM_START_OFF = 4'h1,
    EV_ALARM_ON      = 4'h2,
    EV_ALARM_OFF     = 4'h3,
    EV_START_ON      = 4'h4,
    EV_START_OFF     = 4'h5,
    EV_TRIP_ON       = 4'h6,
    EV_TRIP_OFF      = 4'h7,
    EV_BLOCK_ON      = 4'h8,
    EV_BLOCK_OFF     = 4'h9,
    EV_HARM_ON       = 4'hA,
    EV_HARM_OFF      = 4'hB
  } ev_code_t;
endpackage

// ==== verilog/unbalance_stage_instance.sv ====
// Blocking, status timing, event, counter and fault-record logic of the unbalance stage
module unbalance_stage_instance #(
  parameter int CYCLE_CLKS = unb_stage_pkg::PROG_CYCLE_CLK  // Clocks per program cycle
) (
  input  wire logic                            core_clk,       // Core clock 100 MHz
  input  wire logic                            rstn,           // Async reset, active low
  input  wire logic [unb_stage_pkg::CUR_W-1:0] il1,            // Phase 1 current
  input  wire logic [unb_stage_pkg::CUR_W-1:0] il2,            // Phase 2 current
  input  wire logic [unb_stage_pkg::CUR_W-1:0] il3,            // Phase 3 current
  input  wire logic [15:0]                     alarm_set,      // Alarm level, 0.01 units
  input  wire logic [15:0]                     trip_set,       // Trip level, 0.01 units
  input  wire logic [15:0]                     alarm_delay,    // Alarm delay, 5 ms steps
  input  wire logic [15:0]                     trip_delay,     // Trip delay, 5 ms steps
  input  wire logic                            ext_block,      // Blocking matrix input
  input  wire logic                            harm_enable,    // Inrush blocking enable
  input  wire logic [15:0]                     second_harmonic_ratio, // 0.01 percent
  input  wire logic [15:0]                     harm_limit,     // 0.01 percent
  input  wire logic [2:0]                      setting_group,  // Active group
  input  wire logic [47:0]                     time_stamp,     // Running time stamp
  input  wire logic [5:0]                      ev_on_mask,     // Forward ON events
  input  wire logic [5:0]                      ev_off_mask,    // Forward OFF events
  input  wire logic                            cnt_clear,      // Clear counters
  input  wire logic [3:0]                      rec_idx,        // Record index, 0 newest
  output logic                                 prog_tick,      // Program cycle pulse
  output logic                                 block_sampled,  // Blocking held this cycle
  output logic                                 alarm_start,    // Alarm pick-up
  output logic                                 alarm,          // Alarm operated
  output logic                                 start,          // Trip pick-up
  output logic                                 trip,           // Trip operated
  output logic                                 blocked,        // Pick-up blocked
  output logic                                 harm_block,     // Harmonic block status
  output logic                                 ev_valid,       // Event pulse
  output unb_stage_pkg::ev_code_t              ev_code,        // Event name
  output logic [47:0]                          ev_stamp,       // Event time stamp
  output logic [unb_stage_pkg::CNT_W-1:0]      cnt_alm_start,  // Alarm start count
  output logic [unb_stage_pkg::CNT_W-1:0]      cnt_alarm,      // Alarm count
  output logic [unb_stage_pkg::CNT_W-1:0]      cnt_start,      // Start count
  output logic [unb_stage_pkg::CNT_W-1:0]      cnt_trip,       // Trip count
  output logic [unb_stage_pkg::CNT_W-1:0]      cnt_blocked,    // Blocked count
  output logic                                 rec_valid,      // Record slot filled
  output unb_stage_pkg::ev_code_t              rec_event,      // Record event
  output logic [47:0]                          rec_stamp,      // Record time stamp
  output logic [unb_stage_pkg::CUR_W-1:0]      rec_pre_cur,    // Current 20 ms before
  output logic [unb_stage_pkg::CUR_W-1:0]      rec_fault_cur,  // Current at event
  output logic [unb_stage_pkg::CUR_W-1:0]      rec_prefault_cur, // Current 200 ms before
  output logic [15:0]                          rec_ratio_alarm, // Meas/alarm set, 0.01
  output logic [15:0]                          rec_ratio_trip, // Meas/trip set, 0.01
  output logic [31:0]                          rec_trip_left,  // Trip time left, ms
  output logic [2:0]                           rec_group       // Setting group
);
  import unb_stage_pkg::*;

  // Saturating divide, all-ones on a zero divisor
  function automatic logic [15:0] sat_div(input logic [39:0] n, input logic [39:0] d);
    logic [39:0] q;
    q = (d == 40'h0) ? '1 : n / d;
    return (q > 40'h0000_00FF_FF) ? 16'hFFFF : q[15:0];
  endfunction

  function automatic logic [5:0] hist_at(input logic [5:0] p, input logic [5:0] back);
    logic [6:0] s;
    s = {1'b0, p} + 7'(HIST_DEPTH) - {1'b0, back};
    return (s >= 7'(HIST_DEPTH)) ? 6'(s - 7'(HIST_DEPTH)) : s[5:0];
  endfunction

  //===========================================================================
  // Program cycle tick and unbalance measure
  logic [31:0] tick_cnt_r;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) tick_cnt_r <= '0;
    else if (tick_cnt_r == 32'(CYCLE_CLKS - 1)) tick_cnt_r <= '0;
    else tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
  end
  assign prog_tick = (tick_cnt_r == 32'(CYCLE_CLKS - 1));

  logic [CUR_W-1:0] imax, imin;
  logic [CUR_W+1:0] isum;
  logic [15:0]      unb, ratio_alarm, ratio_trip;
  always_comb begin
    imax = (il1 > il2) ? il1 : il2;
    imax = (il3 > imax) ? il3 : imax;
    imin = (il1 < il2) ? il1 : il2;
    imin = (il3 < imin) ? il3 : imin;
    isum = {2'b00, il1} + {2'b00, il2} + {2'b00, il3};
  end
  assign unb         = sat_div(40'(imax - imin) * 40'(UNB_SCALE), 40'(isum));
  assign ratio_alarm = sat_div(40'(unb) * 40'(PCT_FULL), 40'(alarm_set));
  assign ratio_trip  = sat_div(40'(unb) * 40'(PCT_FULL), 40'(trip_set));

  //===========================================================================
  // Blocking, pick-up and delay timing, all evaluated on the tick
  logic harm_now, blk_now;
  logic pa_r, pt_r, pa_nxt, pt_nxt, blk_nxt, as_nxt, st_nxt, al_nxt, tr_nxt;
  logic [15:0] acnt_r, tcnt_r, acnt_nxt, tcnt_nxt;
  logic [NUM_STATUS-1:0] stat_r, stat_nxt;

  assign harm_now = harm_enable && (second_harmonic_ratio >= harm_limit);
  assign blk_now  = ext_block || harm_now;

  // Release compares at 97 percent so a level sitting on the threshold cannot chatter
  function automatic logic pick(input logic held, input logic [15:0] set);
    return held ? !(24'(unb) * 24'(PCT_FULL) < 24'(set) * 24'(RELEASE_PCT))
                : (unb >= set);
  endfunction

  always_comb begin
    pa_nxt   = pick(pa_r, alarm_set);
    pt_nxt   = pick(pt_r, trip_set);
    // Once blocked, stays blocked until the pick-up itself goes away
    blk_nxt  = (pa_nxt || pt_nxt) && (stat_r[ST_BLOCK] || blk_now);
    as_nxt   = pa_nxt && !blk_nxt;
    st_nxt   = pt_nxt && !blk_nxt;
    // Release handling: timers fall back to zero whenever the pick-up drops
    acnt_nxt = !as_nxt ? 16'h0000 : (acnt_r == 16'hFFFF) ? acnt_r : acnt_r + 16'h0001;
    tcnt_nxt = !st_nxt ? 16'h0000 : (tcnt_r == 16'hFFFF) ? tcnt_r : tcnt_r + 16'h0001;
    al_nxt   = as_nxt && (acnt_nxt >= alarm_delay);
    tr_nxt   = st_nxt && (tcnt_nxt >= trip_delay);
    stat_nxt = {harm_now, blk_nxt, tr_nxt, st_nxt, al_nxt, as_nxt};
  end

  logic blk_smp_r;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      blk_smp_r <= 1'b0;
      pa_r      <= 1'b0;
      pt_r      <= 1'b0;
      acnt_r    <= '0;
      tcnt_r    <= '0;
      stat_r    <= '0;
    end else if (prog_tick) begin
      blk_smp_r <= blk_now;
      pa_r      <= pa_nxt;
      pt_r      <= pt_nxt;
      acnt_r    <= acnt_nxt;
      tcnt_r    <= tcnt_nxt;
      stat_r    <= stat_nxt;
    end
  end
  assign block_sampled = blk_smp_r;
  assign alarm_start   = stat_r[ST_ALM_START];
  assign alarm         = stat_r[ST_ALARM];
  assign start         = stat_r[ST_START];
  assign trip          = stat_r[ST_TRIP];
  assign blocked       = stat_r[ST_BLOCK];
  assign harm_block    = stat_r[ST_HARM];

  //===========================================================================
  // Events: changes queue as pending bits, drained lowest code first
  logic [NUM_STATUS-1:0]   rise, fall;
  logic [2*NUM_STATUS-1:0] pend_r, pend_new, grant;
  logic [3:0]              gidx;
  always_comb begin
    rise = prog_tick ? (stat_nxt & ~stat_r) : '0;
    fall = prog_tick ? (~stat_nxt & stat_r) : '0;
    for (int i = 0; i < NUM_STATUS; i++) begin
      pend_new[2*i]   = rise[i] && ev_on_mask[i];
      pend_new[2*i+1] = fall[i] && ev_off_mask[i];
    end
    grant = pend_r & (~pend_r + 12'h001);
    gidx  = 4'h0;
    for (int i = 0; i < 2 * NUM_STATUS; i++) begin
      if (grant[i]) gidx = 4'(i);
    end
  end
  // All events of one tick share its stamp; the queue empties long before the next tick
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pend_r   <= '0;
      ev_valid <= 1'b0;
      ev_code  <= EV_ALM_START_ON;
      ev_stamp <= '0;
    end else begin
      pend_r   <= (pend_r & ~grant) | pend_new;
      ev_valid <= |pend_r;
      if (|pend_r) ev_code <= ev_code_t'(gidx);
      if (prog_tick) ev_stamp <= time_stamp;
    end
  end

  //===========================================================================
  // Cumulative counters; an increment in the clear cycle survives as one
  logic [CNT_W-1:0]        cnt_r [NUM_COUNTERS];
  logic [NUM_COUNTERS-1:0] cnt_inc;
  assign cnt_inc = rise[ST_BLOCK:ST_ALM_START];
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_COUNTERS; i++) cnt_r[i] <= '0;
    end else begin
      for (int i = 0; i < NUM_COUNTERS; i++) begin
        if (cnt_clear) cnt_r[i] <= CNT_W'(cnt_inc[i]);
        else if (cnt_inc[i]) cnt_r[i] <= cnt_r[i] + 1'b1;
      end
    end
  end
  assign cnt_alm_start = cnt_r[ST_ALM_START];
  assign cnt_alarm     = cnt_r[ST_ALARM];
  assign cnt_start     = cnt_r[ST_START];
  assign cnt_trip      = cnt_r[ST_TRIP];
  assign cnt_blocked   = cnt_r[ST_BLOCK];

  //===========================================================================
  // Current history, one peak phase value per program cycle
  logic [CUR_W-1:0] hist [HIST_DEPTH];
  logic [5:0]       hptr_r;
  always_ff @(posedge core_clk) begin
    if (prog_tick) hist[hptr_r] <= imax;
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) hptr_r <= '0;
    else if (prog_tick) hptr_r <= (hptr_r == 6'(HIST_DEPTH - 1)) ? 6'h00 : hptr_r + 6'h01;
  end

  //===========================================================================
  // Fault records, twelve deep circular
  logic            rec_we;
  ev_code_t        rec_code;
  logic [3:0]      wptr_r, rptr;
  logic [4:0]      rcnt_r;
  ev_code_t        r_ev   [REC_DEPTH];
  logic [47:0]     r_ts   [REC_DEPTH];
  logic [CUR_W-1:0] r_pre [REC_DEPTH];
  logic [CUR_W-1:0] r_flt [REC_DEPTH];
  logic [CUR_W-1:0] r_pf  [REC_DEPTH];
  logic [15:0]     r_ra   [REC_DEPTH];
  logic [15:0]     r_rt   [REC_DEPTH];
  logic [31:0]     r_tl   [REC_DEPTH];
  logic [2:0]      r_grp  [REC_DEPTH];

  // One record per tick; trip outranks start outranks blocked
  assign rec_we   = rise[ST_START] || rise[ST_TRIP] || rise[ST_BLOCK];
  assign rec_code = rise[ST_TRIP] ? EV_TRIP_ON : rise[ST_START] ? EV_START_ON : EV_BLOCK_ON;

  always_ff @(posedge core_clk) begin
    if (rec_we) begin
      r_ev[wptr_r]  <= rec_code;
      r_ts[wptr_r]  <= time_stamp;
      r_pre[wptr_r] <= hist[hist_at(hptr_r, 6'(PRE_TRIG_CYC))];
      r_flt[wptr_r] <= imax;
      r_pf[wptr_r]  <= hist[hptr_r];
      r_ra[wptr_r]  <= ratio_alarm;
      r_rt[wptr_r]  <= ratio_trip;
      r_tl[wptr_r]  <= (tcnt_nxt >= trip_delay) ? 32'h0000_0000 :
                       32'(trip_delay - tcnt_nxt) * 32'(DELAY_STEP_MS);
      r_grp[wptr_r] <= setting_group;
    end
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wptr_r <= '0;
      rcnt_r <= '0;
    end else if (rec_we) begin
      wptr_r <= (wptr_r == 4'(REC_DEPTH - 1)) ? 4'h0 : wptr_r + 4'h1;
      if (rcnt_r != 5'(REC_DEPTH)) rcnt_r <= rcnt_r + 5'h01;
    end
  end

  assign rptr = (wptr_r > rec_idx) ? 4'(wptr_r - rec_idx - 4'h1)
                                   : 4'(wptr_r + 4'(REC_DEPTH) - rec_idx - 4'h1);
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rec_valid        <= 1'b0;
      rec_event        <= EV_ALM_START_ON;
      rec_stamp        <= '0;
      rec_pre_cur      <= '0;
      rec_fault_cur    <= '0;
      rec_prefault_cur <= '0;
      rec_ratio_alarm  <= '0;
      rec_ratio_trip   <= '0;
      rec_trip_left    <= '0;
      rec_group        <= '0;
    end else begin
      rec_valid <= ({1'b0, rec_idx} < rcnt_r);
      if ({1'b0, rec_idx} < rcnt_r) begin
        rec_event        <= r_ev[rptr];
        rec_stamp        <= r_ts[rptr];
        rec_pre_cur      <= r_pre[rptr];
        rec_fault_cur    <= r_flt[rptr];
        rec_prefault_cur <= r_pf[rptr];
        rec_ratio_alarm  <= r_ra[rptr];
        rec_ratio_trip   <= r_rt[rptr];
        rec_trip_left    <= r_tl[rptr];
        rec_group        <= r_grp[rptr];
      end
    end
  end

  //===========================================================================
  // Checks
  property p_blk_hold;
    @(posedge core_clk) disable iff (!rstn) !prog_tick |=> $stable(block_sampled);
  endproperty
  a_blk_hold: assert property (p_blk_hold) else $error("block sample moved off tick");

  property p_start_cause;
    @(posedge core_clk) disable iff (!rstn) $rose(start) |-> $past(prog_tick) && !blocked;
  endproperty
  a_start_cause: assert property (p_start_cause) else $error("start rose wrongly");

  property p_harm_off;
    @(posedge core_clk) disable iff (!rstn)
      prog_tick && !harm_enable |=> !harm_block;
  endproperty
  a_harm_off: assert property (p_harm_off) else $error("harmonic block while off");

  property p_excl;
    @(posedge core_clk) disable iff (!rstn) blocked |-> !start && !alarm_start && !trip;
  endproperty
  a_excl: assert property (p_excl) else $error("blocked with start active");

  property p_cancel;
    @(posedge core_clk) disable iff (!rstn)
      prog_tick && start && blk_now |=> !start && !trip && tcnt_r == 16'h0000;
  endproperty
  a_cancel: assert property (p_cancel) else $error("start not cancelled");

  property p_ev_mask;
    @(posedge core_clk) disable iff (!rstn)
      ev_valid |-> (ev_code[0] ? ev_off_mask[ev_code[3:1]] : ev_on_mask[ev_code[3:1]]);
  endproperty
  a_ev_mask: assert property (p_ev_mask) else $error("masked event forwarded");

  property p_ev_drain;
    @(posedge core_clk) disable iff (!rstn) prog_tick && |pend_new |-> ##[1:13] ev_valid;
  endproperty
  a_ev_drain: assert property (p_ev_drain) else $error("event not emitted");

  property p_clear;
    @(posedge core_clk) disable iff (!rstn)
      cnt_clear |=> cnt_start <= 16'h0001 && cnt_trip <= 16'h0001 && cnt_blocked <= 16'h0001;
  endproperty
  a_clear: assert property (p_clear) else $error("counters not cleared");

  property p_rec_cause;
    @(posedge core_clk) disable iff (!rstn)
      $changed(wptr_r) |-> $past(prog_tick) && $past(stat_nxt[ST_BLOCK:ST_START] != 3'b000);
  endproperty
  a_rec_cause: assert property (p_rec_cause) else $error("record without ON event");

  property p_alarm_delay;
    @(posedge core_clk) disable iff (!rstn) $rose(alarm) |-> acnt_r >= alarm_delay;
  endproperty
  a_alarm_delay: assert property (p_alarm_delay) else $error("alarm before delay");

  property p_rec_depth;
    @(posedge core_clk) disable iff (!rstn) rcnt_r <= 5'(REC_DEPTH) && wptr_r < 4'(REC_DEPTH);
  endproperty
  a_rec_depth: assert property (p_rec_depth) else $error("record store overrun");
endmodule

// ==== verif/unb_far_side.sv ====
// Blocking matrix and event sink model facing the unbalance stage
module unb_far_side (
  input  wire logic                     core_clk,   // Core clock
  input  wire logic                     rstn,       // Async reset, active low
  input  wire logic                     blk_req,    // Bench order to block
  output logic                          ext_block,  // Blocking matrix output
  output logic [47:0]                   time_stamp, // Running time stamp
  input  wire logic                     ev_valid,   // Event pulse
  input  wire unb_stage_pkg::ev_code_t  ev_code     // Event name
);
  timeunit 1ns;
  timeprecision 1ps;
  import unb_stage_pkg::*;
  ev_code_t got[$];
  //===========================================================================
  // Matrix output
  // Registered so it moves just after an edge, as the real matrix does
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ext_block  <= 1'b0;
      time_stamp <= 48'h0000_0000_0000;
    end else begin
      ext_block  <= blk_req;
      time_stamp <= time_stamp + 48'h0000_0000_0001;
    end
  end
  //===========================================================================
  // Event buffer
  // Never stalls: the stage has no back-pressure input
  always @(posedge core_clk) begin
    if (rstn && ev_valid === 1'b1) begin
      got.push_back(ev_code);
    end
  end
endmodule

// ==== verif/test_unbalance_stage_instance.sv ====
// Self-checking bench for the unbalance stage blocking, event and record logic
module test_unbalance_stage_instance;
  timeunit 1ns;
  timeprecision 1ps;
  import unb_stage_pkg::*;
  logic core_clk, rstn, ext_block, harm_enable, cnt_clear, blk_req, block_sampled;
  logic prog_tick, alarm_start, alarm, start, trip, blocked, harm_block, ev_valid, rec_valid;
  logic [15:0] il1, il2, il3, alarm_set, trip_set, alarm_delay, trip_delay, shr, harm_limit;
  logic [15:0] cnt_alm_start, cnt_alarm, cnt_start, cnt_trip, cnt_blocked, rec_fault_cur;
  logic [47:0] time_stamp;
  logic [5:0]  on_m, off_m;
  logic [3:0]  rec_idx;
  ev_code_t    ev_code, rec_event;
  int n_fail = 0;
  int n_compared = 0;
  int cycles = 0;
  unbalance_stage_instance #(.CYCLE_CLKS(20)) dut (
    .core_clk(core_clk), .rstn(rstn), .il1(il1), .il2(il2), .il3(il3),
    .alarm_set(alarm_set), .trip_set(trip_set), .alarm_delay(alarm_delay),
    .trip_delay(trip_delay), .ext_block(ext_block), .harm_enable(harm_enable),
    .second_harmonic_ratio(shr), .harm_limit(harm_limit), .setting_group(3'h1),
    .time_stamp(time_stamp), .ev_on_mask(on_m), .ev_off_mask(off_m),
    .cnt_clear(cnt_clear), .rec_idx(rec_idx), .prog_tick(prog_tick),
    .block_sampled(block_sampled), .alarm_start(alarm_start), .alarm(alarm),
    .start(start), .trip(trip), .blocked(blocked), .harm_block(harm_block),
    .ev_valid(ev_valid), .ev_code(ev_code), .ev_stamp(), .cnt_alm_start(cnt_alm_start),
    .cnt_alarm(cnt_alarm), .cnt_start(cnt_start), .cnt_trip(cnt_trip),
    .cnt_blocked(cnt_blocked), .rec_valid(rec_valid), .rec_event(rec_event),
    .rec_stamp(), .rec_pre_cur(), .rec_fault_cur(rec_fault_cur), .rec_prefault_cur(),
    .rec_ratio_alarm(), .rec_ratio_trip(), .rec_trip_left(), .rec_group()
  );
  unb_far_side far (
    .core_clk(core_clk), .rstn(rstn), .blk_req(blk_req), .ext_block(ext_block),
    .time_stamp(time_stamp), .ev_valid(ev_valid), .ev_code(ev_code)
  );
  //===========================================================================
  // Clock, timeout and helpers
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 4000) begin
      n_fail++;
      final_report();
    end
  end
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(string name, logic [47:0] exp, logic [47:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  // Status is settled one step after the edge that took the tick
  task automatic wait_ticks(int n);
    repeat (n) @(posedge core_clk iff prog_tick === 1'b1);
    #1;
  endtask
  //===========================================================================
  // Scenarios
  task automatic t_start();
    far.got.delete();
    il1 = 16'h00C8;
    wait_ticks(1);
    chk("start", 1, start);
    chk("alarm_start", 1, alarm_start);
    wait_ticks(2);
    chk("trip", 1, trip);
    repeat (4) @(posedge core_clk);
    #1;
    chk("ev count", 4, far.got.size());
    chk("ev0", EV_ALM_START_ON, far.got[0]);
    chk("ev1", EV_ALARM_ON, far.got[1]);
    chk("ev2", EV_START_ON, far.got[2]);
    chk("ev3", EV_TRIP_ON, far.got[3]);
    chk("cnt_trip", 1, cnt_trip);
    chk("cnt_alarm", 1, cnt_alarm);
    chk("rec0", EV_TRIP_ON, rec_event);
    chk("rec0 fault cur", 16'h00C8, rec_fault_cur);
    rec_idx = 4'h1;
    repeat (2) @(posedge core_clk);
    #1;
    chk("rec1", EV_START_ON, rec_event);
    rec_idx = 4'h2;
    repeat (2) @(posedge core_clk);
    #1;
    chk("rec2 valid", 0, rec_valid);
    rec_idx = 4'h0;
  endtask
  task automatic t_block_late();
    blk_req = 1'b1;
    wait_ticks(2);
    chk("start cleared", 0, start);
    chk("trip cleared", 0, trip);
    chk("blocked", 1, blocked);
    chk("cnt_blocked", 1, cnt_blocked);
    chk("block_sampled", 1, block_sampled);
    il1 = 16'h0064;
    blk_req = 1'b0;
    wait_ticks(2);
    blk_req = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    blk_req = 1'b0;
    wait_ticks(1);
    chk("short block", 0, block_sampled);
  endtask
  task automatic t_block_first();
    blk_req = 1'b1;
    wait_ticks(2);
    il1 = 16'h00C8;
    wait_ticks(4);
    chk("blocked", 1, blocked);
    chk("no start", 0, start);
    chk("no trip", 0, trip);
    chk("cnt_start", 1, cnt_start);
    il1 = 16'h0064;
    blk_req = 1'b0;
    wait_ticks(2);
  endtask
  task automatic t_harm();
    shr = HARM_LIM_DEF;
    wait_ticks(2);
    chk("harm off", 0, harm_block);
    harm_enable = 1'b1;
    il1 = 16'h00C8;
    wait_ticks(2);
    chk("harm on", 1, harm_block);
    chk("harm blocks start", 0, start);
    shr = HARM_LIM_DEF - 16'h0001;
    il1 = 16'h0064;
    wait_ticks(2);
    chk("harm below", 0, harm_block);
  endtask
  task automatic t_mask();
    on_m = 6'h00;
    far.got.delete();
    il1 = 16'h00C8;
    wait_ticks(1);
    il1 = 16'h0064;
    wait_ticks(1);
    repeat (6) @(posedge core_clk);
    #1;
    chk("ev masked", 3, far.got.size());
    chk("ev off", EV_ALM_START_OFF, far.got[0]);
    chk("ev off alarm", EV_ALARM_OFF, far.got[1]);
    chk("ev off start", EV_START_OFF, far.got[2]);
    cnt_clear = 1'b1;
    @(posedge core_clk);
    #1;
    cnt_clear = 1'b0;
    chk("cnt cleared", 0, cnt_start | cnt_alm_start | cnt_blocked);
    chk("rec kept", 1, rec_valid);
  endtask
  //===========================================================================
  // Main sequence
  initial begin
    rstn = 1'b0;
    {il1, il2, il3} = {3{16'h0064}};
    {alarm_set, trip_set} = {2{16'h0032}};
    alarm_delay = 16'h0001;
    trip_delay = 16'h0002;
    {harm_enable, cnt_clear, blk_req} = 3'h0;
    shr = 16'h0000;
    harm_limit = HARM_LIM_DEF;
    {on_m, off_m} = 12'hFFF;
    rec_idx = 4'h0;
    repeat (6) @(posedge core_clk);
    #1;
    rstn = 1'b1;
    chk("rec after reset", 0, rec_valid);
    t_start();
    t_block_late();
    t_block_first();
    t_harm();
    t_mask();
    final_report();
  end
endmodule
